// File: cascadable_timer_pkg.sv
package cascadable_timer_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_LOW_CTL = 8'h00;
  localparam logic [7:0] OFF_HIGH_CTL = 8'h04;
  localparam logic [7:0] OFF_LOW_CNT = 8'h08;
  localparam logic [7:0] OFF_HIGH_CNT = 8'h0C;
  localparam logic [7:0] OFF_LOW_PER = 8'h10;
  localparam logic [7:0] OFF_HIGH_PER = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;

  // Control word layout, msb first
  typedef struct packed {
    logic run_control;
    logic rsv14;
    logic idle_stop_select;
    logic [5:0] rsv12_7;
    logic gated_accum_enable;
    logic [1:0] prescale_select;
    logic join_pair_select;
    logic rsv2;
    logic clock_source_select;
    logic rsv0;
  } ctl_t;

  // Writable bits; the rest read as zero
  localparam logic [15:0] LOW_CTL_WMASK = 16'h_A07A;
  localparam logic [15:0] HIGH_CTL_WMASK = 16'h_A072;
  localparam logic [15:0] CTL_RESET = 16'h_0000;
  localparam logic [15:0] CNT_RESET = 16'h_0000;
  localparam logic [15:0] PER_RESET = 16'h_FFFF;

  // Flag register bit positions
  localparam int FLAG_LOW_BIT = 0;
  localparam int FLAG_HIGH_BIT = 1;

  // Prescale codes and terminal counts
  localparam logic [1:0] PSEL_DIV1 = 2'h0;
  localparam logic [1:0] PSEL_DIV8 = 2'h1;
  localparam logic [1:0] PSEL_DIV64 = 2'h2;
  localparam logic [1:0] PSEL_DIV256 = 2'h3;
  localparam logic [7:0] PSC_TC_1 = 8'h00;
  localparam logic [7:0] PSC_TC_8 = 8'h07;
  localparam logic [7:0] PSC_TC_64 = 8'h3F;
  localparam logic [7:0] PSC_TC_256 = 8'hFF;

  // Pin synchroniser lanes
  localparam int SYNC_STAGES = 3;
  localparam int NUM_PINS = 4;
  localparam int PIN_LOW_CLK = 0;
  localparam int PIN_HIGH_CLK = 1;
  localparam int PIN_LOW_GATE = 2;
  localparam int PIN_HIGH_GATE = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cascadable_timer_pkg

// File: prescale_tick.sv
`timescale 1ns/10ps
module prescale_tick
  import cascadable_timer_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [1:0] psel_i,
  output logic adv_o
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] tc;

  always_comb begin
    case (psel_i)
      PSEL_DIV1: tc = CNT_W'(PSC_TC_1);
      PSEL_DIV8: tc = CNT_W'(PSC_TC_8);
      PSEL_DIV64: tc = CNT_W'(PSC_TC_64);
      PSEL_DIV256: tc = CNT_W'(PSC_TC_256);
      default: tc = CNT_W'(PSC_TC_1);
    endcase
  end

  // Stopped timer restarts with a fresh prescale phase
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (!run_i) begin
      cnt_r <= '0;
    end else if (tick_i) begin
      cnt_r <= (cnt_r == tc) ? '0 : cnt_r + CNT_W'(1);
    end
  end

  assign adv_o = run_i & tick_i & (cnt_r == tc);

endmodule : prescale_tick

// File: cascadable_timer_pair.sv
`timescale 1ns/10ps
// Overview of operation
// - Runs as one 32-bit timer or two independent 16-bit timers.
// - Split halves support all 16-bit modes except asynchronous counting.
// - Joined pair offers 32-bit timer and synchronised external counter modes.
// - Joined mode raises an interrupt when 32-bit count meets 32-bit period.
// - Joined period match sets the high half's flag, never the low's.
// - Low half holds count bits 15:0, high half bits 31:16.
// - Joined mode ignores all high control bits; low control rules.
// - Joined counter uses the low half's clock and gate sources.
// - Each split half acts as synchronous timer or synchronous counter.
// - Event trigger output comes only from the joined pair.
// - Each half exports its count as a capture/compare time base.
// - Gated accumulation, prescaler, and counting during idle or sleep.
// - Run bit starts/stops the pair when joined, else the low half.
// - Idle-stop bit chooses whether the low half halts in idle.
// - Unimplemented control bits, including 14 and 12..7, read zero.
// - Bit 6 enables gate-driven counting of the low half.
// - Join bit set forms one 32-bit timer; clear keeps two 16-bit.
// - Gating ignored on external clock; active with internal clock.
module cascadable_timer_pair
  import cascadable_timer_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins and power state
  input wire logic low_clk_pin_i,
  input wire logic high_clk_pin_i,
  input wire logic low_gate_pin_i,
  input wire logic high_gate_pin_i,
  input wire logic idle_mode_i,
  // Time base and events
  output logic [15:0] low_count_o,
  output logic [15:0] high_count_o,
  output logic low_flag_o,
  output logic high_flag_o,
  output logic event_trig_o
);

  ctl_t low_ctl_r;
  ctl_t high_ctl_r;
  logic [15:0] low_cnt_r;
  logic [15:0] high_cnt_r;
  logic [15:0] low_per_r;
  logic [15:0] high_per_r;
  logic low_flag_r;
  logic high_flag_r;
  logic event_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree

  logic [NUM_PINS-1:0] sync_r [SYNC_STAGES];
  logic [NUM_PINS-1:0] pin_vec;
  logic [NUM_PINS-1:0] stable_r;
  logic [NUM_PINS-1:0] agree;
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;

  assign pin_vec = {high_gate_pin_i, low_gate_pin_i, high_clk_pin_i, low_clk_pin_i};
  assign agree = ~(sync_r[1] ^ sync_r[2]);
  assign rise = agree & sync_r[1] & ~stable_r;
  assign fall = agree & ~sync_r[1] & stable_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_r[i] <= '0;
      end
    end else begin
      sync_r[0] <= pin_vec;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stable_r <= '0;
    end else begin
      stable_r <= (agree & sync_r[1]) | (~agree & stable_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source, gating and run control

  logic joined;
  logic low_run;
  logic high_run;
  logic low_tick;
  logic high_tick;
  logic low_adv;
  logic high_adv;
  logic low_gate_done;
  logic high_gate_done;

  assign joined = low_ctl_r.join_pair_select;
  // Idle halts only when asked; sleep never gates the count
  assign low_run = low_ctl_r.run_control
                 & ~(idle_mode_i & low_ctl_r.idle_stop_select);
  // High control is dead while joined
  assign high_run = ~joined & high_ctl_r.run_control
                  & ~(idle_mode_i & high_ctl_r.idle_stop_select);

  // External edges come only through the synchroniser: no async counting
  always_comb begin
    if (low_ctl_r.clock_source_select) begin
      low_tick = rise[PIN_LOW_CLK];
    end else if (low_ctl_r.gated_accum_enable) begin
      low_tick = stable_r[PIN_LOW_GATE];
    end else begin
      low_tick = 1'b1;
    end
  end

  always_comb begin
    if (high_ctl_r.clock_source_select) begin
      high_tick = rise[PIN_HIGH_CLK];
    end else if (high_ctl_r.gated_accum_enable) begin
      high_tick = stable_r[PIN_HIGH_GATE];
    end else begin
      high_tick = 1'b1;
    end
  end

  // Gate closing ends one accumulation window
  assign low_gate_done = low_run & ~low_ctl_r.clock_source_select
                       & low_ctl_r.gated_accum_enable & fall[PIN_LOW_GATE];
  assign high_gate_done = high_run & ~high_ctl_r.clock_source_select
                        & high_ctl_r.gated_accum_enable & fall[PIN_HIGH_GATE];

  prescale_tick #(
    .CNT_W(8)
  ) u_low_psc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(low_run),
    .tick_i(low_tick),
    .psel_i(low_ctl_r.prescale_select),
    .adv_o(low_adv)
  );

  prescale_tick #(
    .CNT_W(8)
  ) u_high_psc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(high_run),
    .tick_i(high_tick),
    .psel_i(high_ctl_r.prescale_select),
    .adv_o(high_adv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side

  logic aw_hold_r;
  logic w_hold_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic [7:0] wword;

  assign wr_fire = aw_hold_r & w_hold_r & ~s_axi_bvalid_o;
  assign wword = {waddr_r[7:2], 2'b00};

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [DATA_W-1:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_r <= 1'b0;
      waddr_r <= '0;
      s_axi_awready_o <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold_r <= 1'b1;
      waddr_r <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end else if (!aw_hold_r && !s_axi_bvalid_o) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w_hold_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_wready_o <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold_r <= 1'b1;
      wdata_r <= s_axi_wdata_i;
      wstrb_r <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end else if (!w_hold_r && !s_axi_bvalid_o) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      case (wword)
        OFF_LOW_CTL, OFF_HIGH_CTL, OFF_LOW_CNT, OFF_HIGH_CNT,
        OFF_LOW_PER, OFF_HIGH_PER, OFF_FLAGS: s_axi_bresp_o <= RESP_OKAY;
        default: s_axi_bresp_o <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Control and period registers; reserved bits never store
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_ctl_r <= CTL_RESET;
      high_ctl_r <= CTL_RESET;
      low_per_r <= PER_RESET;
      high_per_r <= PER_RESET;
    end else if (wr_fire) begin
      case (wword)
        OFF_LOW_CTL: low_ctl_r <= merge16(low_ctl_r, wdata_r, wstrb_r) & LOW_CTL_WMASK;
        OFF_HIGH_CTL: high_ctl_r <= merge16(high_ctl_r, wdata_r, wstrb_r) & HIGH_CTL_WMASK;
        OFF_LOW_PER: low_per_r <= merge16(low_per_r, wdata_r, wstrb_r);
        OFF_HIGH_PER: high_per_r <= merge16(high_per_r, wdata_r, wstrb_r);
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counters: low half is bits 15:0, high half bits 31:16

  logic [31:0] cnt32;
  logic [31:0] per32;
  logic match32;
  logic low_match;
  logic high_match;
  logic [15:0] low_cnt_nxt;
  logic [15:0] high_cnt_nxt;

  assign cnt32 = {high_cnt_r, low_cnt_r};
  assign per32 = {high_per_r, low_per_r};
  assign match32 = joined & low_adv & (cnt32 == per32);
  assign low_match = ~joined & low_adv & (low_cnt_r == low_per_r);
  assign high_match = high_adv & (high_cnt_r == high_per_r);

  always_comb begin
    low_cnt_nxt = low_cnt_r;
    high_cnt_nxt = high_cnt_r;
    if (joined) begin
      // One 32-bit counter advanced by the low half's prescaler
      if (match32) begin
        low_cnt_nxt = '0;
        high_cnt_nxt = '0;
      end else if (low_adv) begin
        {high_cnt_nxt, low_cnt_nxt} = cnt32 + 32'h_0000_0001;
      end
    end else begin
      if (low_match) begin
        low_cnt_nxt = '0;
      end else if (low_adv) begin
        low_cnt_nxt = low_cnt_r + 16'h_0001;
      end
      if (high_match) begin
        high_cnt_nxt = '0;
      end else if (high_adv) begin
        high_cnt_nxt = high_cnt_r + 16'h_0001;
      end
    end
  end

  // A software write to a count wins over the advance in that cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_r <= CNT_RESET;
      high_cnt_r <= CNT_RESET;
    end else begin
      if (wr_fire && wword == OFF_LOW_CNT) begin
        low_cnt_r <= merge16(low_cnt_r, wdata_r, wstrb_r);
      end else begin
        low_cnt_r <= low_cnt_nxt;
      end
      if (wr_fire && wword == OFF_HIGH_CNT) begin
        high_cnt_r <= merge16(high_cnt_r, wdata_r, wstrb_r);
      end else begin
        high_cnt_r <= high_cnt_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: set beats a clear in the same cycle

  logic low_set;
  logic high_set;
  logic flag_clr_low;
  logic flag_clr_high;

  assign low_set = ~joined & (low_match | low_gate_done);
  // Joined pair reports through the high half's flag only
  assign high_set = joined ? (match32 | low_gate_done)
                           : (high_match | high_gate_done);
  assign flag_clr_low = wr_fire & (wword == OFF_FLAGS) & wstrb_r[0]
                      & wdata_r[FLAG_LOW_BIT];
  assign flag_clr_high = wr_fire & (wword == OFF_FLAGS) & wstrb_r[0]
                       & wdata_r[FLAG_HIGH_BIT];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_flag_r <= 1'b0;
      high_flag_r <= 1'b0;
    end else begin
      low_flag_r <= low_set | (low_flag_r & ~flag_clr_low);
      high_flag_r <= high_set | (high_flag_r & ~flag_clr_high);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_r <= 1'b0;
    end else begin
      event_r <= match32;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side

  logic [DATA_W-1:0] rd_word;
  logic rd_ok;

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case ({s_axi_araddr_i[7:2], 2'b00})
      OFF_LOW_CTL: rd_word = {16'h_0000, low_ctl_r};
      OFF_HIGH_CTL: rd_word = {16'h_0000, high_ctl_r};
      OFF_LOW_CNT: rd_word = {16'h_0000, low_cnt_r};
      OFF_HIGH_CNT: rd_word = {16'h_0000, high_cnt_r};
      OFF_LOW_PER: rd_word = {16'h_0000, low_per_r};
      OFF_HIGH_PER: rd_word = {16'h_0000, high_per_r};
      OFF_FLAGS: rd_word = {30'h_0000_0000, high_flag_r, low_flag_r};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end else if (!s_axi_rvalid_o) begin
      s_axi_arready_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops

  assign low_count_o = low_cnt_r;
  assign high_count_o = high_cnt_r;
  assign low_flag_o = low_flag_r;
  assign high_flag_o = high_flag_r;
  assign event_trig_o = event_r;

endmodule : cascadable_timer_pair

// File: cascadable_timer_pair_checker.sv
`timescale 1ns/10ps
module cascadable_timer_pair_checker
  import cascadable_timer_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [DATA_W-1:0] s_axi_rdata_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic high_flag_o,
  input wire logic event_trig_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] rd_addr_r;
  logic rd_take;
  assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
  // Address of the read in flight, to judge its data
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_addr_r <= 8'h00;
    end else if (rd_take) begin
      rd_addr_r <= s_axi_araddr_i;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  wr_answer_a:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##2 s_axi_bvalid_o) else $error("write response late");
  wr_ready_a:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write ready during response");
  rd_answer_a:
    assert property (rd_take |=> s_axi_rvalid_o) else $error("read response late");
  rd_upper_a:
    assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h_0000)
      else $error("upper read bits set");
  ctl_zero_a:
    assert property (s_axi_rvalid_o && rd_addr_r == OFF_LOW_CTL
      |-> (s_axi_rdata_o[15:0] & ~LOW_CTL_WMASK) == 16'h_0000)
      else $error("unimplemented control bit set");
  rd_unmapped_a:
    assert property (rd_take && {s_axi_araddr_i[7:2], 2'b00} > OFF_FLAGS
      |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h_0000_0000)
      else $error("unmapped read not refused");
  trig_pulse_a:
    assert property (event_trig_o |=> !event_trig_o) else $error("trigger longer than one");
  trig_flag_a:
    assert property (event_trig_o |-> high_flag_o) else $error("trigger without high flag");
  cover property (rd_take && s_axi_araddr_i > OFF_FLAGS);
  cover property (event_trig_o);
  cover property ($rose(high_flag_o));
endmodule : cascadable_timer_pair_checker

bind cascadable_timer_pair cascadable_timer_pair_checker chk_u (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o),
  .high_flag_o(high_flag_o),
  .event_trig_o(event_trig_o)
);

// File: cascadable_timer_pair_tb_top.sv
`timescale 1ns/10ps
module cascadable_timer_pair_tb_top;
  import cascadable_timer_pkg::*;
  logic clk, rst, awv, wv, bre, arv, rre, lck, lg, idle;
  logic awr, wr_rdy, bv, arr, rv, lf, hf, et;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr;
  logic [15:0] lc, hc;
  int mismatches, total_checks, cyc, ev;
  int gap [4] = '{1, 8, 64, 256};
  cascadable_timer_pair dut_u (
    .sys_clk_i(clk), .rst_i(rst),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .low_clk_pin_i(lck), .high_clk_pin_i(1'b0), .low_gate_pin_i(lg),
    .high_gate_pin_i(1'b0), .idle_mode_i(idle),
    .low_count_o(lc), .high_count_o(hc), .low_flag_o(lf), .high_flag_o(hf),
    .event_trig_o(et)
  );
  always #2 clk = ~clk;
  // Hang guard; also tallies trigger pulses
  always @(posedge clk) begin
    cyc++;
    if (et === 1'b1) ev++;
    if (cyc > 30000) begin
      mismatches++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n
  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    // Each channel dropped at the edge that takes it; bready held until bvalid
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, br});
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rre <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rr});
    chk("rdata", e, rd);
  endtask : rdc
  //////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rdc(OFF_LOW_CTL, 32'h0, RESP_OKAY);
    rdc(OFF_LOW_PER, 32'h_0000_FFFF, RESP_OKAY);
    wr(OFF_LOW_CTL, 32'h_0000_FFFF, RESP_OKAY);
    rdc(OFF_LOW_CTL, {16'h0, LOW_CTL_WMASK}, RESP_OKAY);
    wr(OFF_HIGH_CTL, 32'h_0000_FFFF, RESP_OKAY);
    rdc(OFF_HIGH_CTL, {16'h0, HIGH_CTL_WMASK}, RESP_OKAY);
    wr(OFF_HIGH_CTL, 32'h0, RESP_OKAY);
    wr(OFF_LOW_CTL, 32'h0, RESP_OKAY);
    wr(8'h40, 32'h1, RESP_SLVERR);
    rdc(8'h40, 32'h0, RESP_SLVERR);
    $display("registers done");
  endtask : t_regs
  task t_presc;
    int n;
    logic [15:0] p;
    for (int i = 0; i < 4; i++) begin
      wr(OFF_LOW_CTL, 32'h_8000 | (i << 4), RESP_OKAY);
      n = 0;
      p = lc;
      while (lc === p) @(posedge clk);
      p = lc;
      while (lc === p) begin
        @(posedge clk);
        n++;
      end
      chk("tick gap", gap[i], n);
    end
    wr(OFF_LOW_CTL, 32'h0, RESP_OKAY);
    $display("prescaler done");
  endtask : t_presc
  task t_split;
    logic [15:0] p;
    wr(OFF_LOW_CNT, 32'h0, RESP_OKAY);
    wr(OFF_FLAGS, 32'h3, RESP_OKAY);
    wr(OFF_LOW_PER, 32'h4, RESP_OKAY);
    ev = 0;
    wr(OFF_LOW_CTL, 32'h_8000, RESP_OKAY);
    wait_n(12);
    wr(OFF_LOW_CTL, 32'h0, RESP_OKAY);
    chk("low flag", 1, lf);
    chk("high flag", 0, hf);
    chk("trigger", 0, ev);
    p = lc;
    wait_n(10);
    chk("stopped", p, lc);
    rdc(OFF_FLAGS, 32'h1, RESP_OKAY);
    wr(OFF_FLAGS, 32'h3, RESP_OKAY);
    rdc(OFF_FLAGS, 32'h0, RESP_OKAY);
    $display("split done");
  endtask : t_split
  task t_join;
    int n;
    wr(OFF_LOW_CNT, 32'h_FFF0, RESP_OKAY);
    wr(OFF_HIGH_CNT, 32'h0, RESP_OKAY);
    wr(OFF_LOW_PER, 32'h2, RESP_OKAY);
    wr(OFF_HIGH_PER, 32'h1, RESP_OKAY);
    wr(OFF_LOW_CTL, 32'h_0008, RESP_OKAY);
    // Slow, running high control must have no effect
    wr(OFF_HIGH_CTL, 32'h_8030, RESP_OKAY);
    ev = 0;
    wr(OFF_LOW_CTL, 32'h_8008, RESP_OKAY);
    n = 0;
    while (hc !== 16'h1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk("carry low", 0, lc);
    chk("carry wait", 1, n < 30);
    wait_n(6);
    chk("high flag", 1, hf);
    chk("low flag", 0, lf);
    chk("trigger", 1, ev);
    wr(OFF_HIGH_CTL, 32'h0, RESP_OKAY);
    wr(OFF_LOW_CTL, 32'h0, RESP_OKAY);
    wr(OFF_FLAGS, 32'h3, RESP_OKAY);
    $display("joined done");
  endtask : t_join
  task t_idle;
    // Short period left by the joined test would wrap the count to zero
    wr(OFF_LOW_PER, 32'h_FFFF, RESP_OKAY);
    wr(OFF_LOW_CNT, 32'h0, RESP_OKAY);
    idle <= 1'b1;
    wr(OFF_LOW_CTL, 32'h_A000, RESP_OKAY);
    wait_n(20);
    chk("idle stop", 0, lc);
    wr(OFF_LOW_CTL, 32'h_8000, RESP_OKAY);
    wait_n(20);
    chk("idle run", 1, lc != 16'h0);
    idle <= 1'b0;
    wr(OFF_LOW_CTL, 32'h0, RESP_OKAY);
    $display("idle done");
  endtask : t_idle
  task t_gate;
    wr(OFF_FLAGS, 32'h3, RESP_OKAY);
    wr(OFF_LOW_CNT, 32'h0, RESP_OKAY);
    wr(OFF_LOW_CTL, 32'h_8040, RESP_OKAY);
    wait_n(20);
    chk("gate closed", 0, lc);
    lg <= 1'b1;
    wait_n(20);
    lg <= 1'b0;
    wait_n(10);
    chk("gate open", 1, lc != 16'h0);
    chk("gate end", 1, lf);
    wr(OFF_LOW_CNT, 32'h0, RESP_OKAY);
    // Gate stays low: gating must be ignored on the pin clock
    wr(OFF_LOW_CTL, 32'h_8042, RESP_OKAY);
    repeat (5) begin
      wait_n(4);
      lck <= 1'b1;
      wait_n(4);
      lck <= 1'b0;
    end
    wait_n(8);
    chk("pin count", 5, lc);
    wr(OFF_LOW_CTL, 32'h0, RESP_OKAY);
    wr(OFF_FLAGS, 32'h3, RESP_OKAY);
    $display("gate and pin done");
  endtask : t_gate
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, awv, wv, bre, arv, rre, lck, lg, idle} = '0;
    {awa, ara, wd} = '0;
    rst = 1'b1;
    wait_n(2);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_presc();
    t_split();
    t_join();
    t_idle();
    t_gate();
    end_sim();
  end
endmodule : cascadable_timer_pair_tb_top
